// ==== include/fsps_defines.vh ====
// fsps_defines.vh - constants of the flash self-programming sequencer
// assumes: included by bare name from design files under hw/
`ifndef FSPS_DEFINES_VH
`define FSPS_DEFINES_VH

// register byte offsets on apb
`define FSPS_OFF_CONTROL 12'h000
`define FSPS_OFF_KEY 12'h004
`define FSPS_OFF_ADDR_HIGH 12'h008
`define FSPS_OFF_ADDR_LOW 12'h00c
`define FSPS_OFF_IRQ_STATUS 12'h010
`define FSPS_OFF_IRQ_CLEAR 12'h014
`define FSPS_OFF_IRQ_ENABLE 12'h018
`define FSPS_ADDR_W 12

// control register fields
`define FSPS_CTL_START 15
`define FSPS_CTL_ENABLE 14
`define FSPS_CTL_ERROR 13
`define FSPS_CTL_ERASE 0

// unlock key values
`define FSPS_KEY_FIRST 8'h55
`define FSPS_KEY_SECOND 8'haa

// field widths of the address and key registers
`define FSPS_HIGH_W 8
`define FSPS_LOW_W 16
`define FSPS_KEY_W 8

// interrupt status bits
`define FSPS_IRQ_DONE 0
`define FSPS_IRQ_REFUSED 1
`define FSPS_IRQ_W 2

// word-pair alignment: bit 1 of the target set, bit 0 clear
`define FSPS_ALIGN_MASK 24'h000003
`define FSPS_ALIGN_VALUE 24'h000002

// default operation durations, 20 ns cycles
`define FSPS_ERASE_CYCLES 16'h0400
`define FSPS_PROG_CYCLES 16'h0100
`define FSPS_CNT_W 16

`endif

// ==== hw/fsps_op_timer.v ====
// fsps_op_timer.v - down-counter timing one flash operation
// assumes: load is a one-cycle pulse, synchronous active-high reset
`include "fsps_defines.vh"
`default_nettype none

module fsps_op_timer (
  input wire mclk_in,
  input wire srst_in,
  input wire load_in,
  input wire [`FSPS_CNT_W-1:0] count_in,
  output reg busy_out,
  output reg done_out
);

  reg [`FSPS_CNT_W-1:0] remain;

  // counts down while busy, pulses done on the last cycle
  always @(posedge mclk_in) begin
    if (srst_in) begin
      remain <= {`FSPS_CNT_W{1'b0}};
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (load_in && !busy_out) begin
        remain <= count_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (remain <= {{(`FSPS_CNT_W-1){1'b0}}, 1'b1}) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          remain <= remain - {{(`FSPS_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // fsps_op_timer

`default_nettype wire

// ==== hw/fsps_sequencer.v ====
// fsps_sequencer.v - run-time self-programming sequencer with apb slave
// assumes: apb master on mclk_in, flash array driven by op strobes
// assumes: durations come from parameters; the array gives no done signal
// assumes: one operation at a time; the core sits stalled until it ends
// Summary of operation
// - two operations: erase one page, or program a pair of instruction words
// - processor held stalled while an operation runs
// - bit 15 of control starts the operation and clears itself when done
// - program writes two 24-bit words at an address ending in binary 10
// - no operation proceeds without the unlock key sequence first
// - unlock is two consecutive key writes: 0x55 then 0xaa
// - key register is write-only and reads back zero
// - address registers form a 24-bit target address for word or page
// - high register gives upper 8 bits, low register lower 16 bits
// - control register enables and starts; seven registers form the interface
`include "fsps_defines.vh"
`default_nettype none

module fsps_sequencer #(
  parameter [`FSPS_CNT_W-1:0] ERASE_CYCLES = `FSPS_ERASE_CYCLES,
  parameter [`FSPS_CNT_W-1:0] PROG_CYCLES = `FSPS_PROG_CYCLES
) (
  input wire mclk_in,
  input wire srst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`FSPS_ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire [47:0] prog_data_in,
  output reg cpu_stall_out,
  output reg flash_erase_out,
  output reg flash_prog_out,
  output reg [23:0] flash_addr_out,
  output reg [47:0] flash_data_out,
  output reg irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // state

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_END = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg ctl_start;
  reg ctl_enable;
  reg ctl_erase;
  reg ctl_error;
  reg [7:0] addr_high;
  reg [15:0] addr_low;
  reg key_half;
  reg unlocked;
  reg [`FSPS_IRQ_W-1:0] irq_status;
  reg [`FSPS_IRQ_W-1:0] irq_enable;
  reg timer_load;
  reg [`FSPS_CNT_W-1:0] timer_count;
  wire timer_busy;
  wire timer_done;

  wire [23:0] target = {addr_high, addr_low};
  wire wr_go = psel_in && penable_in && pwrite_in && !pready_out;
  wire rd_go = psel_in && penable_in && !pwrite_in && !pready_out;
  // address decode, one wire per register
  wire hit_ctl = paddr_in == `FSPS_OFF_CONTROL;
  wire hit_key = paddr_in == `FSPS_OFF_KEY;
  wire hit_high = paddr_in == `FSPS_OFF_ADDR_HIGH;
  wire hit_low = paddr_in == `FSPS_OFF_ADDR_LOW;
  wire hit_stat = paddr_in == `FSPS_OFF_IRQ_STATUS;
  wire hit_clr = paddr_in == `FSPS_OFF_IRQ_CLEAR;
  wire hit_ena = paddr_in == `FSPS_OFF_IRQ_ENABLE;
  // unmapped offsets answer with an error; a write there still breaks the key sequence
  wire known = hit_ctl || hit_key || hit_high || hit_low || hit_stat || hit_clr || hit_ena;
  // write-one-clear strobes for the sticky status bits
  wire clr_done = wr_go && hit_clr && pwdata_in[`FSPS_IRQ_DONE];
  wire clr_refused = wr_go && hit_clr && pwdata_in[`FSPS_IRQ_REFUSED];
  // erase ignores alignment, program needs a word-pair target
  wire aligned = (target & `FSPS_ALIGN_MASK) == `FSPS_ALIGN_VALUE;
  // start request from software, only honoured when idle
  wire start_req = wr_go && hit_ctl && pwdata_in[`FSPS_CTL_START] && state == ST_IDLE;
  wire start_ok = start_req && unlocked && pwdata_in[`FSPS_CTL_ENABLE] &&
                  (pwdata_in[`FSPS_CTL_ERASE] || aligned);
  wire start_bad = start_req && !start_ok;

  ////////////////////////////////////////////////////////////////////////
  // operation timer

  fsps_op_timer fsps_op_timer_inst (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .load_in(timer_load),
    .count_in(timer_count),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // next state of the sequence
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (timer_done) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave and register file

  // one wait state: answer in the cycle after penable rises
  // trade-off: the fixed wait keeps pready a flop at the cost of a cycle
  always @(posedge mclk_in) begin
    if (srst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !known;
      prdata_out <= 32'h00000000;
      if (rd_go) begin
        case (paddr_in)
          `FSPS_OFF_CONTROL: begin
            prdata_out[`FSPS_CTL_START] <= ctl_start;
            prdata_out[`FSPS_CTL_ENABLE] <= ctl_enable;
            prdata_out[`FSPS_CTL_ERROR] <= ctl_error;
            prdata_out[`FSPS_CTL_ERASE] <= ctl_erase;
          end
          `FSPS_OFF_ADDR_HIGH: prdata_out[`FSPS_HIGH_W-1:0] <= addr_high;
          `FSPS_OFF_ADDR_LOW: prdata_out[`FSPS_LOW_W-1:0] <= addr_low;
          `FSPS_OFF_IRQ_STATUS: prdata_out[`FSPS_IRQ_W-1:0] <= irq_status;
          `FSPS_OFF_IRQ_ENABLE: prdata_out[`FSPS_IRQ_W-1:0] <= irq_enable;
          // key, clear and unmapped offsets all read zero
          default: prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // control fields; a control write while busy leaves them unchanged, but its start bit still clears the unlock
  always @(posedge mclk_in) begin
    if (srst_in) begin
      ctl_enable <= 1'b0;
      ctl_erase <= 1'b0;
      ctl_error <= 1'b0;
    end else if (wr_go && hit_ctl && state == ST_IDLE) begin
      ctl_enable <= pwdata_in[`FSPS_CTL_ENABLE];
      ctl_erase <= pwdata_in[`FSPS_CTL_ERASE];
      ctl_error <= start_bad;
    end
  end

  // start bit: set by an accepted launch, cleared by hardware at the end
  always @(posedge mclk_in) begin
    if (srst_in) begin
      ctl_start <= 1'b0;
    end else if (start_ok) begin
      ctl_start <= 1'b1;
    end else if (state == ST_END) begin
      ctl_start <= 1'b0;
    end
  end

  // address registers, frozen while an operation runs so the target
  // seen by the array cannot drift under it
  always @(posedge mclk_in) begin
    if (srst_in) begin
      addr_high <= {`FSPS_HIGH_W{1'b0}};
      addr_low <= {`FSPS_LOW_W{1'b0}};
    end else if (state == ST_IDLE) begin
      if (wr_go && hit_high) begin
        addr_high <= pwdata_in[`FSPS_HIGH_W-1:0];
      end
      if (wr_go && hit_low) begin
        addr_low <= pwdata_in[`FSPS_LOW_W-1:0];
      end
    end
  end

  // interrupt enable, writable at any time
  always @(posedge mclk_in) begin
    if (srst_in) begin
      irq_enable <= {`FSPS_IRQ_W{1'b0}};
    end else if (wr_go && hit_ena) begin
      irq_enable <= pwdata_in[`FSPS_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unlock key tracking

  // any apb write other than a key write of 0xaa or of 0x55 right after 0x55 breaks the sequence
  // limitation: reads between the two key writes do not break it
  always @(posedge mclk_in) begin
    if (srst_in) begin
      key_half <= 1'b0;
      unlocked <= 1'b0;
    end else begin
      if (wr_go) begin
        key_half <= hit_key && pwdata_in[`FSPS_KEY_W-1:0] == `FSPS_KEY_FIRST;
        if (hit_key && key_half && pwdata_in[`FSPS_KEY_W-1:0] == `FSPS_KEY_SECOND) begin
          unlocked <= 1'b1;
        end else if (hit_ctl && pwdata_in[`FSPS_CTL_START]) begin
          unlocked <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer and flash strobes

  // state register; the end state lasts one cycle so the done flag and
  // the start-bit clear land together
  always @(posedge mclk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // timer load and duration, picked by the erase bit of the start write
  always @(posedge mclk_in) begin
    if (srst_in) begin
      timer_load <= 1'b0;
      timer_count <= {`FSPS_CNT_W{1'b0}};
    end else begin
      timer_load <= start_ok;
      if (start_ok) begin
        timer_count <= pwdata_in[`FSPS_CTL_ERASE] ? ERASE_CYCLES : PROG_CYCLES;
      end
    end
  end

  // one-cycle launch strobes; the kind is fixed by the write that starts
  always @(posedge mclk_in) begin
    if (srst_in) begin
      flash_erase_out <= 1'b0;
      flash_prog_out <= 1'b0;
    end else begin
      flash_erase_out <= start_ok && pwdata_in[`FSPS_CTL_ERASE];
      flash_prog_out <= start_ok && !pwdata_in[`FSPS_CTL_ERASE];
    end
  end

  // target and word pair captured at launch and held for the whole run,
  // so later bus traffic cannot move an operation already under way
  always @(posedge mclk_in) begin
    if (srst_in) begin
      flash_addr_out <= 24'h000000;
      flash_data_out <= 48'h000000000000;
    end else if (start_ok) begin
      flash_addr_out <= target;
      flash_data_out <= prog_data_in;
    end
  end

  // core stall: rises with the launch, falls as the timer reports done
  always @(posedge mclk_in) begin
    if (srst_in) begin
      cpu_stall_out <= 1'b0;
    end else if (start_ok) begin
      cpu_stall_out <= 1'b1;
    end else if (next_state == ST_END) begin
      cpu_stall_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over clear

  // sticky bits: an event in the cycle of its clear keeps the bit set,
  // so software never loses an event it has not yet seen
  always @(posedge mclk_in) begin
    if (srst_in) begin
      irq_status <= {`FSPS_IRQ_W{1'b0}};
    end else begin
      irq_status[`FSPS_IRQ_DONE] <= (state == ST_END) || (irq_status[`FSPS_IRQ_DONE] && !clr_done);
      irq_status[`FSPS_IRQ_REFUSED] <= start_bad || (irq_status[`FSPS_IRQ_REFUSED] && !clr_refused);
    end
  end

  // level interrupt from a flop; it trails the status bits by one cycle
  always @(posedge mclk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_enable);
    end
  end

endmodule // fsps_sequencer

`default_nettype wire

// ==== verif/fsps_flash_model.sv ====
// flash array stand-in: records each launch the sequencer makes
// assumes: erase and program strobes are one-cycle pulses on mclk_in
`default_nettype none
module fsps_flash_model #(parameter int PAGE_W = 10) (
  input wire logic mclk_in,
  input wire logic flash_erase_out,
  input wire logic flash_prog_out,
  input wire logic [23:0] flash_addr_out,
  input wire logic [47:0] flash_data_out,
  output var int ops_out,
  output var int bad_out,
  output var logic [23:0] addr_seen_out,
  output var logic [47:0] data_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] page = 24'hffffff;
  initial ops_out = 0;
  initial bad_out = 0;
  ////////////////////////////////////////////////////////////////////////
  // page size unknown here, so it is a parameter; a program outside the
  // last erased page is counted as a software slip
  always @(posedge mclk_in) begin
    if (flash_erase_out || flash_prog_out) begin
      ops_out <= ops_out + 1;
      addr_seen_out <= flash_addr_out;
      data_seen_out <= flash_data_out;
    end
    if (flash_erase_out) page <= flash_addr_out >> PAGE_W;
    if (flash_prog_out && (flash_addr_out >> PAGE_W) != page) bad_out <= bad_out + 1;
  end
endmodule // fsps_flash_model
`default_nettype wire

// ==== verif/fsps_sequencer_props.sv ====
// checker on the sequencer's apb and flash launch ports
// assumes: bound to fsps_sequencer, single clock, sync reset
`default_nettype none
module fsps_props (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cpu_stall_out,
  input wire logic flash_erase_out,
  input wire logic flash_prog_out,
  input wire logic [23:0] flash_addr_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  wire launch = flash_erase_out | flash_prog_out;
  // a start write as the slave takes it: access phase, before ready
  wire start_wr = psel_in && penable_in && pwrite_in && !pready_out && paddr_in == 12'h000 && pwdata_in[15];
  sequence s_access;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_start_busy;
    start_wr && cpu_stall_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ready_one_wait: assert property (s_access |=> pready_out) else $error("no ready after access");
  a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready held");
  a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  a_stall_on_launch: assert property (launch |-> cpu_stall_out [*4]) else $error("no stall");
  a_one_kind: assert property (flash_erase_out |-> !flash_prog_out) else $error("two kinds");
  a_prog_aligned: assert property (flash_prog_out |-> flash_addr_out[1:0] == 2'b10) else $error("misaligned");
  a_busy_no_start: assert property (cpu_stall_out && $past(cpu_stall_out) |-> !launch) else $error("relaunch");
  a_launch_by_write: assert property (launch |-> $past(start_wr)) else $error("bad launch");
  a_busy_start_void: assert property (s_start_busy |=> !launch) else $error("start taken while busy");
  a_addr_held: assert property (cpu_stall_out && $past(cpu_stall_out) |-> $stable(flash_addr_out))
    else $error("target moved");
endmodule // fsps_props
`default_nettype wire

// ==== verif/fsps_sequencer_tb.sv ====
// top bench: apb master tasks, random and corner operations
// assumes: design under hw/, flash model and checker under verif/
`default_nettype none
module fsps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, srst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, err;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, cpu_stall_out, flash_erase_out, flash_prog_out, irq_out;
  logic [23:0] flash_addr_out, addr_seen_out, a;
  logic [47:0] prog_data_in = 48'h0, flash_data_out, data_seen_out, pd;
  int num_errors = 0, compares = 0, n, ops_out, bad_out;
  fsps_sequencer #(.ERASE_CYCLES(16'h0020), .PROG_CYCLES(16'h0004)) fsps_sequencer_inst (.mclk_in, .srst_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .prog_data_in, .cpu_stall_out, .flash_erase_out, .flash_prog_out, .flash_addr_out, .flash_data_out, .irq_out);
  fsps_flash_model fsps_flash_model_inst (.mclk_in, .flash_erase_out, .flash_prog_out, .flash_addr_out,
    .flash_data_out, .ops_out, .bad_out, .addr_seen_out, .data_seen_out);
  initial forever #10 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // released with an idle edge after, so no signal is driven twice at once
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    @(posedge mclk_in);
  endtask
  // launch expected only with a good key and, for program, a word-pair target
  function automatic logic go(logic er, logic [23:0] t, logic [1:0] k);
    return k == 2'd1 && (er || t[1:0] == 2'b10);
  endfunction
  // key modes: 0 none, 1 in order, 2 reversed, 3 in order but enable bit clear
  task automatic op(input logic er, input logic [1:0] k);
    int c0;
    c0 = ops_out;
    pd = 48'({$urandom, $urandom});
    prog_data_in <= pd;
    apb(1, 12'h014, 32'h3);
    apb(1, 12'h008, {24'h0, a[23:16]});
    apb(1, 12'h00c, {16'h0, a[15:0]});
    apb(0, 12'h008, 0);
    chk(rd, {24'h0, a[23:16]}, "addr high");
    if (k != 0) apb(1, 12'h004, k[0] ? 32'h55 : 32'haa);
    if (k != 0) apb(1, 12'h004, k[0] ? 32'haa : 32'h55);
    apb(1, 12'h000, {16'h0, 1'b1, k != 2'd3, 13'h0, er});
    chk(cpu_stall_out, go(er, a, k), "stall");
    repeat (2) @(posedge mclk_in);
    // a second unlock and start while the erase runs must be ignored
    if (er && go(er, a, k)) begin
      apb(1, 12'h004, 32'h55);
      apb(1, 12'h004, 32'haa);
      apb(1, 12'h000, {16'h0, 2'b11, 13'h0, er});
      apb(0, 12'h000, 0);
      chk(rd[15], 1, "start while busy");
    end
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (cpu_stall_out !== 1'b0 && n < 80);
    if (cpu_stall_out !== 1'b0) begin
      num_errors++;
      give_verdict();
    end
    repeat (2) @(posedge mclk_in);
    chk(ops_out - c0, go(er, a, k), "launches");
    if (go(er, a, k)) chk(addr_seen_out, a, "target");
    if (go(er, a, k) && !er) chk(data_seen_out, pd, "word pair");
    apb(0, 12'h010, 0);
    chk(rd[1:0], go(er, a, k) ? 2'b01 : 2'b10, "status");
    chk(irq_out, 1, "irq");
    apb(0, 12'h000, 0);
    chk(rd[15], 0, "start bit");
    chk(rd[13], !go(er, a, k), "error bit");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(32'h7c61);
    repeat (12) @(posedge mclk_in);
    srst_in <= 0;
    @(posedge mclk_in);
    apb(0, 12'h000, 0);
    chk(rd, 0, "control reset");
    apb(1, 12'h004, 32'h55);
    apb(0, 12'h004, 0);
    chk(rd, 0, "key read");
    apb(0, 12'h01c, 0);
    chk({err, rd}, 33'h100000000, "unmapped");
    apb(1, 12'h018, 32'h3);
    a = 24'($urandom);
    for (int i = 0; i < 14; i++) begin
      a[9:0] = 10'($urandom);
      if (i < 4) a[1:0] = 2'b10;
      op(i < 2 ? i[0] == 0 : i[0], i < 4 ? 2'd1 : (i == 4 ? 2'd0 : (i == 5 ? 2'd3 : 2'($urandom))));
    end
    chk(bad_out, 0, "unerased program");
    apb(1, 12'h018, 0);
    repeat (2) @(posedge mclk_in);
    chk(irq_out, 0, "irq masked");
    apb(1, 12'h018, 32'h3);
    apb(1, 12'h014, 32'h3);
    repeat (2) @(posedge mclk_in);
    chk(irq_out, 0, "irq cleared");
    give_verdict();
  end
endmodule // fsps_sequencer_tb
bind fsps_sequencer fsps_props fsps_props_inst (.mclk_in, .srst_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .cpu_stall_out, .flash_erase_out, .flash_prog_out,
  .flash_addr_out);
`default_nettype wire
